// [src/dsc_slave.sv]
// Drive serial slave: link framing, register map, run qualification
`timescale 1ns/1ps
`default_nettype none
`include "dsc_defs.svh"
module dsc_slave import dsc_pkg::*; #(
  parameter int CLK_HZ = `DSC_CLK_HZ
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic rxd,
  output logic txd,
  output logic txd_oe_n,
  input wire logic [7:0] station_addr,
  input wire logic [2:0] baud_sel,
  input wire logic ref_src_com,
  input wire logic proc_src_bus,
  input wire dsc_word_t ext_ref,
  input wire dsc_word_t ext_proc,
  input wire dsc_fault_e detach_mode,
  input wire dsc_fault_e link_fault_mode,
  input wire logic panel_detached,
  input wire logic trip_in,
  output dsc_run_s run_cmd,
  output dsc_word_t speed_ref,
  output dsc_word_t process_value,
  output dsc_status_s status
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  function automatic logic [19:0] baud_div(input logic [2:0] sel);
    int b;
    case (sel)
      3'h0: b = `DSC_BAUD_2400;
      3'h1: b = `DSC_BAUD_4800;
      3'h2: b = `DSC_BAUD_9600;
      3'h3: b = `DSC_BAUD_19200;
      3'h4: b = `DSC_BAUD_38400;
      3'h5: b = `DSC_BAUD_57600;
      default: b = `DSC_BAUD_115200;
    endcase
    return 20'(CLK_HZ / b);
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `DSC_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  dsc_state_e state_reg;
  logic [19:0] div;
  logic [22:0] gap_cycles;
  assign div = baud_div(baud_sel);
  assign gap_cycles = 23'(div) * `DSC_GAP_BITS;

  // Receiver
  logic rx_busy_reg, byte_stb_reg, byte_fe_reg;
  logic [19:0] rx_cnt_reg;
  logic [3:0] rx_bit_reg;
  logic [9:0] rx_sh_reg;
  logic [7:0] byte_reg;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_busy_reg <= 1'b0;
      rx_cnt_reg <= '0;
      rx_bit_reg <= '0;
      rx_sh_reg <= '0;
      byte_stb_reg <= 1'b0;
      byte_fe_reg <= 1'b0;
      byte_reg <= '0;
    end else begin
      byte_stb_reg <= 1'b0;
      if (!rx_busy_reg) begin
        if (state_reg == DSC_RX && !rxd) begin
          rx_busy_reg <= 1'b1;
          rx_cnt_reg <= div >> 1;
          rx_bit_reg <= '0;
        end
      end else if (rx_cnt_reg != '0) begin
        rx_cnt_reg <= rx_cnt_reg - 20'h1;
      end else begin
        rx_cnt_reg <= div - 20'h1;
        rx_bit_reg <= rx_bit_reg + 4'h1;
        if (rx_bit_reg == '0 && rxd) begin
          // Glitch, not a start bit
          rx_busy_reg <= 1'b0;
        end else if (rx_bit_reg == `DSC_LAST_BIT) begin
          rx_busy_reg <= 1'b0;
          byte_stb_reg <= 1'b1;
          byte_reg <= rx_sh_reg[8:1];
          byte_fe_reg <= !(rx_sh_reg[9] && rxd);
        end else if (rx_bit_reg != '0) begin
          // Eight data then the first stop bit; the second is sampled last
          rx_sh_reg <= {rxd, rx_sh_reg[9:1]};
        end
      end
    end
  end

  rx_quiet_a: assert property (rx_busy_reg |-> txd_oe_n)
    else $error("driver enabled while a character is received");

  // Inter-frame silence
  logic [22:0] gap_cnt_reg;
  logic frame_end;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gap_cnt_reg <= '0;
    end else if (rx_busy_reg || !rxd || state_reg != DSC_RX) begin
      gap_cnt_reg <= '0;
    end else if (gap_cnt_reg != gap_cycles) begin
      gap_cnt_reg <= gap_cnt_reg + 23'h1;
    end
  end

  // Frame collection
  logic [7:0] frm_buf [0:7];
  logic [3:0] rx_n_reg;
  logic frm_bad_reg;
  logic [15:0] rx_crc_reg;
  assign frame_end = state_reg == DSC_RX && gap_cnt_reg == gap_cycles && rx_n_reg != '0;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_n_reg <= '0;
      frm_bad_reg <= 1'b0;
      rx_crc_reg <= `DSC_CRC_INIT;
      for (int i = 0; i < 8; i++) begin
        frm_buf[i] <= '0;
      end
    end else if (state_reg == DSC_EXEC) begin
      rx_n_reg <= '0;
      frm_bad_reg <= 1'b0;
      rx_crc_reg <= `DSC_CRC_INIT;
    end else if (byte_stb_reg) begin
      if (byte_fe_reg || rx_n_reg == `DSC_FRAME_LEN) begin
        frm_bad_reg <= 1'b1;
      end else begin
        frm_buf[rx_n_reg[2:0]] <= byte_reg;
        rx_n_reg <= rx_n_reg + 4'h1;
        rx_crc_reg <= crc_step(rx_crc_reg, byte_reg);
      end
    end
  end

  stop_discard_a: assert property (byte_stb_reg && byte_fe_reg && state_reg == DSC_RX
    |=> rx_n_reg == $past(rx_n_reg) && frm_bad_reg)
    else $error("character with low stop bit was kept");

  // Request decode
  logic [7:0] fn;
  logic [15:0] a;
  dsc_word_t d;
  logic bcast, good, is_wr, is_rd, hit_cmd, hit_set, hit_mot, bad_val, reply, wr_en;
  logic [4:0] mot_idx;
  logic [7:0] exc;
  assign fn = frm_buf[1];
  assign a = {frm_buf[2], frm_buf[3]};
  assign d = {frm_buf[4], frm_buf[5]};
  assign bcast = frm_buf[0] == `DSC_BROADCAST;
  assign good = !frm_bad_reg && rx_n_reg == `DSC_FRAME_LEN && rx_crc_reg == '0 &&
                (bcast || frm_buf[0] == station_addr);
  assign is_wr = fn == `DSC_FN_WRITE;
  assign is_rd = fn == `DSC_FN_READ;
  assign hit_cmd = a >= `DSC_ADDR_RESET && a <= `DSC_ADDR_PROC;
  always_comb begin
    hit_set = 1'b0;
    hit_mot = 1'b0;
    mot_idx = '0;
    for (int k = 0; k < `DSC_SETS; k++) begin
      if (a >= 16'(`DSC_SET_FIRST + k * `DSC_SET_STRIDE) &&
          a <= 16'(`DSC_SET_LAST + k * `DSC_SET_STRIDE)) begin
        hit_set = 1'b1;
      end
      if (a >= 16'(`DSC_MOTOR_FIRST + k * `DSC_SET_STRIDE) &&
          a < 16'(`DSC_MOTOR_FIRST + k * `DSC_SET_STRIDE + `DSC_MOTOR_WORDS)) begin
        hit_mot = 1'b1;
        mot_idx = 5'(k * `DSC_MOTOR_WORDS) + 5'(a - 16'(`DSC_MOTOR_FIRST + k * `DSC_SET_STRIDE));
      end
    end
  end
  assign bad_val = (a == `DSC_ADDR_REF || a == `DSC_ADDR_PROC) &&
                   ($signed(d) < $signed(`DSC_REF_MIN) || $signed(d) > $signed(`DSC_REF_MAX));
  always_comb begin
    if (!(is_wr || is_rd)) begin
      exc = `DSC_EXC_FUNC;
    end else if (!(hit_cmd || hit_set)) begin
      exc = `DSC_EXC_ADDR;
    end else if ((is_wr && bad_val) || (is_rd && d != `DSC_READ_QTY)) begin
      exc = `DSC_EXC_VALUE;
    end else begin
      exc = '0;
    end
  end
  assign reply = good && !bcast;
  assign wr_en = state_reg == DSC_EXEC && good && is_wr && exc == '0;

  // Register file
  dsc_word_t rst_req_reg, run_reg, cw_reg, ccw_reg, ref_reg, proc_reg, rd_data;
  dsc_word_t mot_mem [0:31];
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_req_reg <= '0;
      run_reg <= '0;
      cw_reg <= '0;
      ccw_reg <= '0;
      ref_reg <= '0;
      proc_reg <= '0;
      for (int i = 0; i < 32; i++) begin
        mot_mem[i] <= '0;
      end
    end else if (wr_en) begin
      case (a)
        `DSC_ADDR_RESET: rst_req_reg <= d;
        `DSC_ADDR_RUN: run_reg <= d;
        `DSC_ADDR_RUN_CW: cw_reg <= d;
        `DSC_ADDR_RUN_CCW: ccw_reg <= d;
        `DSC_ADDR_REF: ref_reg <= d;
        `DSC_ADDR_PROC: proc_reg <= d;
        default: begin
          if (hit_mot) begin
            mot_mem[mot_idx] <= d;
          end
        end
      endcase
    end
  end
  always_comb begin
    case (a)
      `DSC_ADDR_RESET: rd_data = rst_req_reg;
      `DSC_ADDR_RUN: rd_data = run_reg;
      `DSC_ADDR_RUN_CW: rd_data = cw_reg;
      `DSC_ADDR_RUN_CCW: rd_data = ccw_reg;
      `DSC_ADDR_REF: rd_data = ref_reg;
      `DSC_ADDR_PROC: rd_data = proc_reg;
      default: rd_data = hit_mot ? mot_mem[mot_idx] : '0;
    endcase
  end

  ref_range_a: assert property ($signed(ref_reg) >= $signed(`DSC_REF_MIN) &&
    $signed(ref_reg) <= $signed(`DSC_REF_MAX))
    else $error("reference word outside signed range");
  proc_range_a: assert property ($signed(proc_reg) >= $signed(`DSC_REF_MIN) &&
    $signed(proc_reg) <= $signed(`DSC_REF_MAX))
    else $error("process word outside signed range");

  // Transmitter
  logic [7:0] tx_buf [0:5];
  logic [2:0] tx_len_reg;
  // Index runs to length plus two, past three bits
  logic [3:0] tx_idx_reg, tx_len_w;
  logic [3:0] tx_bit_reg;
  logic [19:0] tx_cnt_reg;
  logic [10:0] tx_sh_reg;
  logic [15:0] tx_crc_reg;
  logic tx_tick, tx_done;
  logic [7:0] tx_byte;
  assign tx_len_w = {1'b0, tx_len_reg};
  assign tx_tick = state_reg == DSC_TX && tx_cnt_reg == '0;
  assign tx_done = tx_tick && tx_bit_reg == `DSC_LAST_BIT && tx_idx_reg == tx_len_w + 4'h2;
  always_comb begin
    if (tx_idx_reg < tx_len_w) begin
      tx_byte = tx_buf[tx_idx_reg[2:0]];
    end else if (tx_idx_reg == tx_len_w) begin
      tx_byte = tx_crc_reg[7:0];
    end else begin
      tx_byte = tx_crc_reg[15:8];
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_len_reg <= '0;
      tx_idx_reg <= '0;
      tx_bit_reg <= '0;
      tx_cnt_reg <= '0;
      tx_sh_reg <= '1;
      tx_crc_reg <= `DSC_CRC_INIT;
      for (int i = 0; i < 6; i++) begin
        tx_buf[i] <= '0;
      end
    end else if (state_reg == DSC_EXEC) begin
      tx_idx_reg <= '0;
      tx_bit_reg <= `DSC_LAST_BIT;
      tx_cnt_reg <= '0;
      tx_sh_reg <= '1;
      tx_crc_reg <= `DSC_CRC_INIT;
      tx_buf[0] <= frm_buf[0];
      if (exc != '0) begin
        tx_buf[1] <= fn | `DSC_EXC_FLAG;
        tx_buf[2] <= exc;
        tx_len_reg <= `DSC_LEN_EXC;
      end else if (is_rd) begin
        tx_buf[1] <= fn;
        tx_buf[2] <= `DSC_BYTE_CNT;
        tx_buf[3] <= rd_data[15:8];
        tx_buf[4] <= rd_data[7:0];
        tx_len_reg <= `DSC_LEN_READ;
      end else begin
        for (int i = 1; i < 6; i++) begin
          tx_buf[i] <= frm_buf[i];
        end
        tx_len_reg <= `DSC_LEN_WRITE;
      end
    end else if (state_reg == DSC_TX) begin
      if (tx_cnt_reg != '0) begin
        tx_cnt_reg <= tx_cnt_reg - 20'h1;
      end else begin
        // Each level held one bit period
        tx_cnt_reg <= div - 20'h1;
        if (tx_bit_reg == `DSC_LAST_BIT) begin
          tx_sh_reg <= {2'b11, tx_byte, 1'b0};
          tx_bit_reg <= '0;
          tx_idx_reg <= tx_idx_reg + 4'h1;
          if (tx_idx_reg < tx_len_w) begin
            tx_crc_reg <= crc_step(tx_crc_reg, tx_byte);
          end
        end else begin
          tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
          tx_bit_reg <= tx_bit_reg + 4'h1;
        end
      end
    end
  end
  assign txd = state_reg == DSC_TX ? tx_sh_reg[0] : 1'b1;
  assign txd_oe_n = state_reg != DSC_TX;

  bit_period_a: assert property (tx_tick && !tx_done
    |=> tx_cnt_reg == $past(div) - 20'h1)
    else $error("bit period does not match selected rate");
  stop_high_a: assert property (state_reg == DSC_TX && tx_bit_reg >= `DSC_STOP1_BIT
    |-> txd)
    else $error("stop bit driven low");
  nrz_hold_a: assert property (state_reg == DSC_TX && $changed(txd) |-> $past(tx_tick))
    else $error("line changed inside a bit period");

  // Sequencer
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= DSC_RX;
    end else begin
      unique case (state_reg)
        DSC_RX: begin
          if (frame_end) begin
            state_reg <= DSC_EXEC;
          end
        end
        DSC_EXEC: state_reg <= reply ? DSC_TX : DSC_RX;
        DSC_TX: begin
          if (tx_done) begin
            state_reg <= DSC_RX;
          end
        end
        default: state_reg <= DSC_RX;
      endcase
    end
  end

  // Faults and run qualification
  logic rst_q_reg, trip_reg, link_fault_reg, warn_reg, rst_rise, link_err, trip_set;
  assign rst_rise = rst_req_reg[0] && !rst_q_reg;
  assign link_err = state_reg == DSC_EXEC && (frm_bad_reg || rx_crc_reg != '0);
  assign trip_set = trip_in || (detach_mode == DSC_FLT_TRIP && panel_detached) ||
                    (link_fault_mode == DSC_FLT_TRIP && link_fault_reg);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_q_reg <= 1'b0;
      trip_reg <= 1'b0;
      link_fault_reg <= 1'b0;
      warn_reg <= 1'b0;
    end else begin
      rst_q_reg <= rst_req_reg[0];
      // Edge clears; a new fault wins
      if (trip_set) begin
        trip_reg <= 1'b1;
      end else if (rst_rise) begin
        trip_reg <= 1'b0;
      end
      if (link_err) begin
        link_fault_reg <= 1'b1;
      end else if (rst_rise) begin
        link_fault_reg <= 1'b0;
      end
      warn_reg <= (detach_mode == DSC_FLT_WARN && panel_detached) ||
                  (link_fault_mode == DSC_FLT_WARN && link_fault_reg);
    end
  end

  // Sign of the active reference steers bipolar direction
  dsc_word_t ref_eff;
  assign ref_eff = ref_src_com ? ref_reg : ext_ref;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      run_cmd <= '0;
      speed_ref <= '0;
      process_value <= '0;
    end else begin
      run_cmd.run <= run_reg[0] && (cw_reg[0] || ccw_reg[0]) && !trip_reg;
      run_cmd.bipolar <= cw_reg[0] && ccw_reg[0];
      run_cmd.reverse <= (cw_reg[0] && ccw_reg[0]) ? ref_eff[15] : ccw_reg[0];
      speed_ref <= ref_eff;
      process_value <= proc_src_bus ? proc_reg : ext_proc;
    end
  end
  assign status = '{warning: warn_reg, tripped: trip_reg, comm_fault: link_fault_reg};

  run_qual_a: assert property (run_cmd.run |->
    $past(run_reg[0]) && ($past(cw_reg[0]) || $past(ccw_reg[0])) && !$past(trip_reg))
    else $error("run without general and directional command");
  bipolar_dir_a: assert property (run_cmd.bipolar |->
    $past(cw_reg[0]) && $past(ccw_reg[0]) && run_cmd.reverse == $past(ref_eff[15]))
    else $error("bipolar direction not taken from reference sign");
  edge_reset_a: assert property ($fell(trip_reg) |-> $past(rst_rise))
    else $error("trip cleared without reset edge");
  detach_warn_a: assert property (detach_mode == DSC_FLT_WARN && panel_detached
    |=> warn_reg)
    else $error("panel detach gave no warning");

  answer_c: cover property (tx_done);
  bipolar_c: cover property (run_cmd.bipolar && run_cmd.run);
  reset_c: cover property ($fell(trip_reg));
  frame_err_c: cover property (byte_stb_reg && byte_fe_reg);
endmodule
`default_nettype wire

// [shared/dsc_defs.svh]
// Constants of the drive serial slave control block
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH
// Overview of operation
// - Slave only at a set station address; never drives while master sends.
// - Bit rate selectable from 2400 to 115200 baud, same on both ends.
// - Each character is start bit, eight data bits, two stop bits, no parity.
// - Plain NRZ levels, each bit held one full bit period.
// - Four parameter sets at 43001-43899, repeated every thousand from 44001.
// - Motor data at 43041-43048, repeated every thousand for three more motors.
// - Command words: 42901 fault reset, 42903 clockwise run, 42904 counter run.
// - Motor starts only with general run 42902 plus a directional run.
// - Both directional runs active selects bipolar mode; reference sign sets direction.
// - Serial reference at 42905 when selected; resets zero, range -16384..16384.
// - Process feedback at 42906 when bus source selected; same range, zero default.
// - Reference and process words are 16-bit signed two's complement.
// - Panel detach or serial link fault raises warning or trip as configured.
// - Fault reset acts on rising edge of the reset request only.
`define DSC_CLK_HZ 250000000
`define DSC_BAUD_2400 2400
`define DSC_BAUD_4800 4800
`define DSC_BAUD_9600 9600
`define DSC_BAUD_19200 19200
`define DSC_BAUD_38400 38400
`define DSC_BAUD_57600 57600
`define DSC_BAUD_115200 115200
`define DSC_LAST_BIT 4'hA
`define DSC_STOP1_BIT 4'h9
`define DSC_GAP_BITS 23'h27
`define DSC_ADDR_RESET 16'hA795
`define DSC_ADDR_RUN 16'hA796
`define DSC_ADDR_RUN_CW 16'hA797
`define DSC_ADDR_RUN_CCW 16'hA798
`define DSC_ADDR_REF 16'hA799
`define DSC_ADDR_PROC 16'hA79A
`define DSC_SET_FIRST 16'hA7F9
`define DSC_SET_LAST 16'hAB7B
`define DSC_SET_STRIDE 16'h03E8
`define DSC_SETS 4
`define DSC_MOTOR_FIRST 16'hA821
`define DSC_MOTOR_WORDS 8
`define DSC_REF_MIN 16'hC000
`define DSC_REF_MAX 16'h4000
`define DSC_FN_READ 8'h03
`define DSC_FN_WRITE 8'h06
`define DSC_EXC_FLAG 8'h80
`define DSC_EXC_FUNC 8'h01
`define DSC_EXC_ADDR 8'h02
`define DSC_EXC_VALUE 8'h03
`define DSC_READ_QTY 16'h0001
`define DSC_BYTE_CNT 8'h02
`define DSC_CRC_INIT 16'hFFFF
`define DSC_CRC_POLY 16'hA001
`define DSC_BROADCAST 8'h00
`define DSC_FRAME_LEN 4'h8
`define DSC_LEN_EXC 3'h3
`define DSC_LEN_READ 3'h5
`define DSC_LEN_WRITE 3'h6
`endif

// [shared/dsc_pkg.sv]
// Types of the drive serial slave control block
package dsc_pkg;
  typedef enum logic [1:0] {DSC_RX = 2'b00, DSC_EXEC = 2'b01, DSC_TX = 2'b10} dsc_state_e;
  typedef enum logic [1:0] {
    DSC_FLT_OFF = 2'b00, DSC_FLT_WARN = 2'b01, DSC_FLT_TRIP = 2'b10
  } dsc_fault_e;
  typedef struct packed {
    logic run;
    logic reverse;
    logic bipolar;
  } dsc_run_s;
  typedef struct packed {
    logic warning;
    logic tripped;
    logic comm_fault;
  } dsc_status_s;
  typedef logic [15:0] dsc_word_t;
endpackage

// [bench/dsc_master.sv]
// Serial bus master model facing the slave's link pins
`timescale 1ns/1ps
`default_nettype none
module dsc_master #(
  parameter int BIT_T = 21
) (
  input wire logic clk_sys,
  output logic rxd,
  input wire logic txd,
  input wire logic txd_oe_n
);
  logic [7:0] rx_buf [0:15];
  int rx_cnt;
  int overlap;
  int stop_err;
  initial begin
    rxd = 1'b1;
    rx_cnt = 0;
    overlap = 0;
    stop_err = 0;
  end
  // Reflected CRC-16 over one byte
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
    end
    return r;
  endfunction
  task automatic send_byte(input logic [7:0] b, input logic bad_stop);
    logic [10:0] ch;
    ch = {1'b1, ~bad_stop, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(negedge clk_sys);
      if (txd_oe_n !== 1'b1) overlap++;
      rxd = ch[i];
      repeat (BIT_T - 1) @(negedge clk_sys);
    end
  endtask
  task automatic send_frame(input logic [7:0] addr, input logic [7:0] fn,
                            input logic [15:0] reg_no, input logic [15:0] data,
                            input logic bad_stop);
    logic [7:0] f [0:7];
    logic [15:0] c;
    f = '{addr, fn, reg_no[15:8], reg_no[7:0], data[15:8], data[7:0], 8'h00, 8'h00};
    c = 16'hFFFF;
    for (int i = 0; i < 6; i++) begin
      c = crc_step(c, f[i]);
    end
    f[6] = c[7:0];
    f[7] = c[15:8];
    for (int i = 0; i < 8; i++) begin
      send_byte(f[i], bad_stop && (i == 2));
    end
  endtask
  // Sampled on the falling edge, clear of the slave's updates
  task automatic get_reply();
    int w;
    logic [9:0] sh;
    rx_cnt = 0;
    w = 0;
    while (txd_oe_n !== 1'b0 && w < 45 * BIT_T) begin
      @(negedge clk_sys);
      w++;
    end
    while (txd_oe_n === 1'b0 && rx_cnt < 16) begin
      w = 0;
      while (txd !== 1'b0 && txd_oe_n === 1'b0 && w < 12 * BIT_T) begin
        @(negedge clk_sys);
        w++;
      end
      if (txd !== 1'b0) break;
      repeat (BIT_T / 2) @(negedge clk_sys);
      for (int i = 0; i < 10; i++) begin
        repeat (BIT_T) @(negedge clk_sys);
        sh[i] = txd;
      end
      if (sh[9:8] !== 2'b11) stop_err++;
      rx_buf[rx_cnt] = sh[7:0];
      rx_cnt++;
    end
  endtask
endmodule
`default_nettype wire

// [bench/drive_serial_slave_control_test.sv]
// Self-checking bench of the drive serial slave control block
`timescale 1ns/1ps
`default_nettype none
`include "dsc_defs.svh"
module drive_serial_slave_control_test import dsc_pkg::*; ;
  localparam int CLK_HZ = 2500000;
  localparam int BIT_T = CLK_HZ / 115200;
  localparam logic [7:0] STN = 8'h11;
  typedef struct packed {
    logic [7:0] fn;
    logic [15:0] reg_no;
    logic [15:0] data;
    logic [1:0] kind;
    logic [15:0] exp;
  } dsc_row_s;
  dsc_row_s rows [0:11];
  dsc_row_s r;
  logic clk_sys, arst_n, rxd, txd, txd_oe_n, ref_src_com, proc_src_bus, panel_detached, trip_in;
  logic [7:0] station_addr;
  logic [2:0] baud_sel;
  dsc_word_t ext_ref, ext_proc, speed_ref, process_value;
  dsc_fault_e detach_mode, link_fault_mode;
  dsc_run_s run_cmd;
  dsc_status_s status;
  int err_total;
  int n_tests;
  dsc_master #(.BIT_T(BIT_T)) m (.clk_sys(clk_sys), .rxd(rxd), .txd(txd), .txd_oe_n(txd_oe_n));
  dsc_slave #(.CLK_HZ(CLK_HZ)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .rxd(rxd), .txd(txd),
    .txd_oe_n(txd_oe_n), .station_addr(station_addr), .baud_sel(baud_sel),
    .ref_src_com(ref_src_com), .proc_src_bus(proc_src_bus), .ext_ref(ext_ref),
    .ext_proc(ext_proc), .detach_mode(detach_mode), .link_fault_mode(link_fault_mode),
    .panel_detached(panel_detached), .trip_in(trip_in), .run_cmd(run_cmd),
    .speed_ref(speed_ref), .process_value(process_value), .status(status));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic cmp_v(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_int(input string what, input int exp, input int got);
    n_tests++;
    if (got != exp) begin
      err_total++;
      $display("FAIL %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Kind 0 echo, 1 read, 2 exception, 3 silence
  task automatic xact(input logic [7:0] addr, input logic [7:0] fn, input logic [15:0] reg_no,
                      input logic [15:0] data, input logic [1:0] kind, input logic [15:0] exp,
                      input logic bad);
    logic [7:0] e [0:7];
    int n;
    logic [15:0] c;
    m.send_frame(addr, fn, reg_no, data, bad);
    m.get_reply();
    e = '{addr, fn, reg_no[15:8], reg_no[7:0], data[15:8], data[7:0], 8'h00, 8'h00};
    n = 6;
    if (kind == 2'd1) begin
      e = '{addr, fn, `DSC_BYTE_CNT, exp[15:8], exp[7:0], 8'h00, 8'h00, 8'h00};
      n = 5;
    end else if (kind == 2'd2) begin
      e = '{addr, fn | `DSC_EXC_FLAG, exp[7:0], 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      n = 3;
    end
    c = 16'hFFFF;
    for (int i = 0; i < n; i++) begin
      c = m.crc_step(c, e[i]);
    end
    e[n] = c[7:0];
    e[n + 1] = c[15:8];
    if (kind == 2'd3) n = -2;
    cmp_int("reply length", n + 2, m.rx_cnt);
    for (int i = 0; i < n + 2 && i < m.rx_cnt; i++) begin
      cmp_v("reply byte", {8'h00, e[i]}, {8'h00, m.rx_buf[i]});
    end
  endtask
  task automatic chk_reset();
    cmp_v("idle outputs", 16'h00C0, {8'h00, txd, txd_oe_n, run_cmd, status});
    cmp_v("speed_ref", 16'h0000, speed_ref);
    cmp_v("process_value", 16'h0000, process_value);
  endtask
  task automatic wr(input logic [15:0] reg_no, input logic [15:0] data);
    xact(STN, `DSC_FN_WRITE, reg_no, data, 2'd0, 16'h0000, 1'b0);
  endtask
  // Traffic takes about 82k cycles; margin kept below 100k
  initial begin
    #390us;
    err_total++;
    $display("FAIL watchdog expected done seen hang");
    print_verdict();
  end
  initial begin
    rows = '{
      '{`DSC_FN_WRITE, `DSC_ADDR_RUN_CW, 16'h0001, 2'd0, 16'h0000},
      '{`DSC_FN_READ, `DSC_ADDR_RUN_CW, `DSC_READ_QTY, 2'd1, 16'h0001},
      '{`DSC_FN_WRITE, `DSC_ADDR_REF, 16'hC000, 2'd0, 16'h0000},
      '{`DSC_FN_WRITE, `DSC_ADDR_REF, 16'h4001, 2'd2, {8'h00, `DSC_EXC_VALUE}},
      '{`DSC_FN_READ, `DSC_ADDR_REF, `DSC_READ_QTY, 2'd1, 16'hC000},
      '{`DSC_FN_WRITE, 16'hA821, 16'h1234, 2'd0, 16'h0000},
      '{`DSC_FN_WRITE, 16'hB3E0, 16'hABCD, 2'd0, 16'h0000},
      '{`DSC_FN_READ, 16'hB3E0, `DSC_READ_QTY, 2'd1, 16'hABCD},
      '{`DSC_FN_READ, 16'hAB7B, `DSC_READ_QTY, 2'd1, 16'h0000},
      '{`DSC_FN_READ, 16'hA794, `DSC_READ_QTY, 2'd2, {8'h00, `DSC_EXC_ADDR}},
      '{8'h04, `DSC_ADDR_RESET, `DSC_READ_QTY, 2'd2, {8'h00, `DSC_EXC_FUNC}},
      '{`DSC_FN_READ, `DSC_ADDR_RUN, 16'h0002, 2'd2, {8'h00, `DSC_EXC_VALUE}}};
    arst_n = 1'b0;
    station_addr = STN;
    baud_sel = 3'd6;
    ref_src_com = 1'b1;
    proc_src_bus = 1'b1;
    ext_ref = 16'h0000;
    ext_proc = 16'h0000;
    detach_mode = DSC_FLT_OFF;
    link_fault_mode = DSC_FLT_OFF;
    panel_detached = 1'b0;
    trip_in = 1'b0;
    err_total = 0;
    n_tests = 0;
    repeat (10) @(negedge clk_sys);
    chk_reset();
    arst_n = 1'b1;
    @(negedge clk_sys);
    foreach (rows[i]) begin
      r = rows[i];
      xact(STN, r.fn, r.reg_no, r.data, r.kind, r.exp, 1'b0);
    end
    cmp_v("run_cmd", 16'h0000, {13'h0, run_cmd});
    wr(`DSC_ADDR_RUN, 16'h0001);
    cmp_v("run_cmd", 16'h0004, {13'h0, run_cmd});
    wr(`DSC_ADDR_RUN_CCW, 16'h0001);
    cmp_v("run_cmd", 16'h0007, {13'h0, run_cmd});
    wr(`DSC_ADDR_REF, 16'h0100);
    cmp_v("run_cmd", 16'h0005, {13'h0, run_cmd});
    cmp_v("speed_ref", 16'h0100, speed_ref);
    ref_src_com = 1'b0;
    ext_ref = 16'h8765;
    repeat (2) @(negedge clk_sys);
    cmp_v("speed_ref", 16'h8765, speed_ref);
    ref_src_com = 1'b1;
    xact(`DSC_BROADCAST, `DSC_FN_WRITE, `DSC_ADDR_PROC, 16'hF000, 2'd3, 16'h0,
      1'b0);
    cmp_v("process_value", 16'hF000, process_value);
    proc_src_bus = 1'b0;
    ext_proc = 16'h1357;
    repeat (2) @(negedge clk_sys);
    cmp_v("process_value", 16'h1357, process_value);
    proc_src_bus = 1'b1;
    xact(8'h22, `DSC_FN_READ, `DSC_ADDR_RUN, `DSC_READ_QTY, 2'd3, 16'h0, 1'b0);
    trip_in = 1'b1;
    repeat (3) @(negedge clk_sys);
    trip_in = 1'b0;
    cmp_v("trip and run", 16'h0002, {14'h0, status.tripped, run_cmd.run});
    wr(`DSC_ADDR_RESET, 16'h0001);
    cmp_v("trip and run", 16'h0001, {14'h0, status.tripped, run_cmd.run});
    detach_mode = DSC_FLT_WARN;
    panel_detached = 1'b1;
    repeat (3) @(negedge clk_sys);
    cmp_v("warning", 16'h0001, {15'h0, status.warning});
    link_fault_mode = DSC_FLT_WARN;
    xact(STN, `DSC_FN_WRITE, `DSC_ADDR_RUN, 16'h0000, 2'd3, 16'h0, 1'b1);
    cmp_v("comm_fault", 16'h0001, {15'h0, status.comm_fault});
    cmp_v("run kept", 16'h0001, {15'h0, run_cmd.run});
    trip_in = 1'b1;
    repeat (3) @(negedge clk_sys);
    trip_in = 1'b0;
    // Reset word already high: a level alone must not clear
    wr(`DSC_ADDR_RESET, 16'h0001);
    cmp_v("tripped", 16'h0001, {15'h0, status.tripped});
    cmp_int("overlap", 0, m.overlap);
    cmp_int("stop bits", 0, m.stop_err);
    detach_mode = DSC_FLT_OFF;
    link_fault_mode = DSC_FLT_OFF;
    panel_detached = 1'b0;
    arst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk_reset();
    arst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk_reset();
    // Trip mode of the detach fault, not reached above
    detach_mode = DSC_FLT_TRIP;
    panel_detached = 1'b1;
    repeat (3) @(negedge clk_sys);
    cmp_v("detach trip", 16'h0002, {13'h0, status});
    print_verdict();
  end
endmodule
`default_nettype wire
